// [hw/flash_prot_map.svh]
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH

// command opcodes
`define CMD_READ_PROT_STATUS 8'ha7
`define CMD_LOCK_PROT 8'ha6
`define CMD_GENERIC_READ 8'h65
`define CMD_GENERIC_WRITE 8'h71
`define CMD_BLOCK_LOCK_READ 8'h3d
`define CMD_BLOCK_LOCK_READ4 8'he0
`define CMD_BLOCK_LOCK 8'h36
`define CMD_BLOCK_LOCK4 8'he1
`define CMD_BLOCK_UNLOCK 8'h39
`define CMD_BLOCK_UNLOCK4 8'he2
`define CMD_GLOBAL_LOCK 8'h7e
`define CMD_GLOBAL_UNLOCK 8'h98
`define CMD_SET_POINTER 8'hfb
`define CMD_SET_POINTER4 8'he3

// generic register addresses used by 65h / 71h
`define ADDR_PROT_STATUS 32'h0000_0030
`define ADDR_POINTER_REGION 32'h0000_0040

// lock values
`define LOCK_PROTECTED 8'h00
`define LOCK_OPEN 8'hff
`define LOCK_BOOT_ALT 8'hef

// protection status fields
`define PS_LOCK_BIT 0
`define PS_R3PW_BIT 6

// protection mode bit positions
`define MODE_PERM_BIT 0
`define MODE_PW_BIT 2
`define MODE_BOOT_BIT 4
`define MODE_R3PW_BIT 6

// pointer region fields
`define PTR_RESET 32'hffff_ffff
`define PTR_TB_BIT 9
`define PTR_EN_BIT 10
`define PTR_ALL_BIT 11
`define PTR_ADDR_LSB 12
`define PTR_ADDR_MSB 22

`endif

// [hw/flash_prot_pkg.sv]
package flash_prot_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } rsp_s;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } access_s;

endpackage

// [hw/flash_region_block_protection.sv]
`timescale 1ns/1ps
`include "flash_prot_map.svh"

// How it works
// - status register volatile, reserved bits zero
// - lock low freezes regions and pointer
// - opcode a6 sets configuration lock
// - bit6 mirrors region3 read password
// - bit0 defaults from password, permanent
// - a7 and 65 return status
// - lock access reflects volatile array only
// - boot loads 00 or ef
// - lock commands write 00
// - unlock commands write ff
// - 3d and e0 return lock value
// - pointer written by fb, e3, 71
// - pointer address field defaults ones
// - protect-all covers every sector
// - enable low activates pointer protection
// - top/bottom picks region origin
// - boot bit zero starts unprotected
// - password mode protects regions from boot until a6
// - permanent mode protects without password
module flash_region_block_protection #(
    parameter int NUM_BLOCKS = 128,
    parameter int ADDR_W = 23,
    parameter int BLOCK_LSB = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // protection mode bits from one-time storage
    input wire logic [7:0] protection_mode_bits,
    // decoded command from the serial front end
    input wire flash_prot_pkg::cmd_s cmd,
    // program or erase request from the array sequencer
    input wire flash_prot_pkg::access_s array_req,
    // register read answer
    output flash_prot_pkg::rsp_s rsp,
    // array permission
    output logic array_grant,
    output logic array_deny,
    // region guards for the security region logic
    output logic region23_write_ok,
    output logic region3_read_pw,
    // visible state
    output logic nv_config_lock,
    output logic [31:0] pointer_region_reg
);

    localparam int IDX_W = $clog2(NUM_BLOCKS);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------

    // one cell per block: the index must cover the block span exactly
    if (NUM_BLOCKS < 2) begin : g_bad_count
        $error("flash_region_block_protection: too few blocks");
    end
    if (NUM_BLOCKS != (1 << (ADDR_W - BLOCK_LSB))) begin : g_bad_span
        $error("flash_region_block_protection: block count mismatch");
    end
    // pointer compare works on the fixed a22..a12 field
    if (ADDR_W != `PTR_ADDR_MSB + 1) begin : g_bad_addr
        $error("flash_region_block_protection: address width unsupported");
    end

    // ------------------------------------------------------------
    // boot sequencing
    // ------------------------------------------------------------

    // modes are caught after reset release, never at the async edge
    logic boot_pending_r;
    logic [7:0] mode_r;
    logic boot_load;

    assign boot_load = boot_pending_r;

    // mode bits are programmed to 0, so a 1 means the mode was never chosen
    logic pw_mode_unset;
    logic perm_mode_unset;
    logic lock_boot_set;

    assign pw_mode_unset = protection_mode_bits[`MODE_PW_BIT];
    assign perm_mode_unset = protection_mode_bits[`MODE_PERM_BIT];
    assign lock_boot_set = protection_mode_bits[`MODE_BOOT_BIT];

    // mode copy feeds the status mirror and the read guard

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_pending_r <= 1'b1;
        end else begin
            boot_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_r <= 8'hff;
        end else if (boot_pending_r) begin
            mode_r <= protection_mode_bits;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------

    logic op_lock_prot;
    logic op_status_rd;
    logic op_generic_rd;
    logic op_lock_rd;
    logic op_blk_lock;
    logic op_blk_unlock;
    logic op_glb_lock;
    logic op_glb_unlock;
    logic op_ptr_write;
    logic [IDX_W-1:0] cmd_idx;
    logic addr_is_status;
    logic addr_is_ptr;

    // generic register accesses are steered by address
    assign addr_is_status = (cmd.addr == `ADDR_PROT_STATUS);
    assign addr_is_ptr = (cmd.addr == `ADDR_POINTER_REGION);
    assign op_lock_prot = cmd.valid & (cmd.opcode == `CMD_LOCK_PROT);
    assign op_status_rd = cmd.valid & (cmd.opcode == `CMD_READ_PROT_STATUS);
    assign op_generic_rd = cmd.valid & (cmd.opcode == `CMD_GENERIC_READ);
    assign op_lock_rd = cmd.valid & ((cmd.opcode == `CMD_BLOCK_LOCK_READ) |
                        (cmd.opcode == `CMD_BLOCK_LOCK_READ4));
    assign op_blk_lock = cmd.valid & ((cmd.opcode == `CMD_BLOCK_LOCK) |
                         (cmd.opcode == `CMD_BLOCK_LOCK4));
    assign op_blk_unlock = cmd.valid & ((cmd.opcode == `CMD_BLOCK_UNLOCK) |
                           (cmd.opcode == `CMD_BLOCK_UNLOCK4));
    assign op_glb_lock = cmd.valid & (cmd.opcode == `CMD_GLOBAL_LOCK);
    assign op_glb_unlock = cmd.valid & (cmd.opcode == `CMD_GLOBAL_UNLOCK);
    assign op_ptr_write = cmd.valid & ((cmd.opcode == `CMD_SET_POINTER) |
                          (cmd.opcode == `CMD_SET_POINTER4) |
                          ((cmd.opcode == `CMD_GENERIC_WRITE) & addr_is_ptr));
    // lock commands pick their cell from the block field alone
    assign cmd_idx = cmd.addr[BLOCK_LSB +: IDX_W];

    // ------------------------------------------------------------
    // protection status register
    // ------------------------------------------------------------

    logic lock_r;
    logic lock_default;
    logic lock_nxt;
    logic [7:0] status_val;

    // default open only when neither lasting mode is chosen
    // password mode holds the lock low at boot
    // permanent mode holds the lock low at boot
    assign lock_default = pw_mode_unset & perm_mode_unset;

    // a6 sets the lock to one; boot outranks it in one cycle
    assign lock_nxt = boot_load ? lock_default :
                      op_lock_prot ? 1'b1 : lock_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // volatile read-only, reserved bits read zero
    // bit 6 mirrors region 3 password mode bit
    always_comb begin
        status_val = 8'h00;
        status_val[`PS_LOCK_BIT] = lock_r;
        status_val[`PS_R3PW_BIT] = mode_r[`MODE_R3PW_BIT];
    end

    // ------------------------------------------------------------
    // volatile block lock array
    // ------------------------------------------------------------

    logic [7:0] boot_val;
    logic [7:0] lock_vals [NUM_BLOCKS];

    // boot value from the lock-boot bit
    // bit programmed low starts everything open
    assign boot_val = lock_boot_set ? `LOCK_PROTECTED : `LOCK_BOOT_ALT;

    // only volatile cells, no backing copy
    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_cell
        logic sel;
        logic lock_hit;
        logic open_hit;
        assign sel = (cmd_idx == IDX_W'(i));
        assign lock_hit = op_glb_lock | (op_blk_lock & sel);
        assign open_hit = op_glb_unlock | (op_blk_unlock & sel);
        lock_cell u_cell (
            .clk_sys(clk_sys),
            .rst(rst),
            .boot_val(boot_val),
            .load_boot(boot_load),
            .set_lock(lock_hit),
            .set_open(open_hit),
            .lock_val(lock_vals[i])
        );
    end

    // ------------------------------------------------------------
    // pointer region register
    // ------------------------------------------------------------

    logic [31:0] ptr_r;
    logic [31:0] ptr_nxt;
    logic ptr_write_ok;

    // refused write leaves register as is
    assign ptr_write_ok = op_ptr_write & lock_r & ~boot_load;
    // a write during the boot cycle is dropped, never held over
    assign ptr_nxt = ptr_write_ok ? cmd.wdata : ptr_r;

    // all ones at reset; flops stand in for the nonvolatile cells
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptr_r <= `PTR_RESET;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // array access check
    // ------------------------------------------------------------

    logic ptr_hit;
    logic [IDX_W-1:0] req_idx;
    logic blk_locked;
    logic req_protected;
    logic grant_nxt;
    logic deny_nxt;

    assign req_idx = array_req.addr[BLOCK_LSB +: IDX_W];
    assign blk_locked = (lock_vals[req_idx] == `LOCK_PROTECTED);

    pointer_check #(
        .ADDR_W(ADDR_W),
        .BLOCK_LSB(`PTR_ADDR_LSB)
    ) u_ptr (
        .ptr_reg(ptr_r),
        .target(array_req.addr[ADDR_W-1:0]),
        .hit(ptr_hit)
    );

    assign req_protected = blk_locked | ptr_hit;
    // a refused access only answers deny; the sequencer leaves the array alone
    assign grant_nxt = array_req.valid & ~req_protected;
    assign deny_nxt = array_req.valid & req_protected;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            array_grant <= 1'b0;
            array_deny <= 1'b0;
        end else begin
            array_grant <= grant_nxt;
            array_deny <= deny_nxt;
        end
    end

    // ------------------------------------------------------------
    // read answers
    // ------------------------------------------------------------

    logic [31:0] rd_data;
    logic rd_hit;
    logic gen_status;
    logic gen_ptr;
    logic sel_status;
    logic [31:0] status_word;
    logic [31:0] lock_word;
    logic [31:0] rsp_data_nxt;

    assign gen_status = op_generic_rd & addr_is_status;
    assign gen_ptr = op_generic_rd & addr_is_ptr;
    assign sel_status = op_status_rd | gen_status;
    assign status_word = {24'h00_0000, status_val};
    // only the block field of the address counts, higher bits are ignored
    assign lock_word = {24'h00_0000, lock_vals[cmd_idx]};
    // unmapped generic reads are left to other register blocks
    assign rd_hit = op_status_rd | gen_status | gen_ptr | op_lock_rd;
    assign rd_data = sel_status ? status_word :
                     gen_ptr ? ptr_r :
                     op_lock_rd ? lock_word : 32'h0000_0000;
    // zero between answers so a stale word never rides on a dead strobe
    assign rsp_data_nxt = rd_hit ? rd_data : 32'h0000_0000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= rd_hit;
            rsp.data <= rsp_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // guard outputs
    // ------------------------------------------------------------

    logic write_ok_nxt;
    logic read_pw_nxt;

    // regions 2 and 3 writable only when lock is one
    assign write_ok_nxt = lock_r;
    // region 3 read needs password when both low
    assign read_pw_nxt = ~mode_r[`MODE_R3PW_BIT] & ~lock_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            region23_write_ok <= 1'b0;
            region3_read_pw <= 1'b0;
            nv_config_lock <= 1'b0;
            pointer_region_reg <= `PTR_RESET;
        end else begin
            region23_write_ok <= write_ok_nxt;
            region3_read_pw <= read_pw_nxt;
            // visible copies trail the internal state by one cycle
            nv_config_lock <= lock_r;
            pointer_region_reg <= ptr_r;
        end
    end

endmodule // flash_region_block_protection

// [hw/lock_cell.sv]
`timescale 1ns/1ps
`include "flash_prot_map.svh"

module lock_cell (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // boot value and control
    input wire logic [7:0] boot_val,
    input wire logic load_boot,
    input wire logic set_lock,
    input wire logic set_open,
    // state
    output logic [7:0] lock_val
);

    logic [7:0] lock_r;
    logic [7:0] lock_nxt;

    // lock wins over unlock if both ever coincide: safer side
    assign lock_nxt = load_boot ? boot_val :
                      set_lock ? `LOCK_PROTECTED :
                      set_open ? `LOCK_OPEN : lock_r;

    // reset to protected, boot loader follows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_r <= `LOCK_PROTECTED;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    assign lock_val = lock_r;

endmodule // lock_cell

// [hw/pointer_check.sv]
`timescale 1ns/1ps
`include "flash_prot_map.svh"

module pointer_check #(
    parameter int ADDR_W = 23,
    parameter int BLOCK_LSB = 12
) (
    // pointer register and target
    input wire logic [31:0] ptr_reg,
    input wire logic [ADDR_W-1:0] target,
    // result
    output logic hit
);

    if (ADDR_W != `PTR_ADDR_MSB + 1 || BLOCK_LSB != `PTR_ADDR_LSB) begin : g_bad_geometry
        $error("pointer_check: unsupported address geometry");
    end

    logic [10:0] ptr_blk;
    logic [10:0] tgt_blk;
    logic active;
    logic in_top;
    logic in_bottom;

    assign ptr_blk = ptr_reg[`PTR_ADDR_MSB:`PTR_ADDR_LSB];
    assign tgt_blk = target[ADDR_W-1:BLOCK_LSB];
    assign active = ~ptr_reg[`PTR_EN_BIT];
    assign in_top = tgt_blk >= ptr_blk;
    assign in_bottom = tgt_blk <= ptr_blk;
    assign hit = active & (ptr_reg[`PTR_ALL_BIT] |
                 (ptr_reg[`PTR_TB_BIT] ? in_bottom : in_top));

endmodule // pointer_check

// [tb/flash_prot_checker.sv]
`timescale 1ns/1ps
`include "flash_prot_map.svh"

module flash_prot_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // inputs
    input wire logic [7:0] protection_mode_bits,
    input wire flash_prot_pkg::cmd_s cmd,
    input wire flash_prot_pkg::access_s array_req,
    // outputs
    input wire flash_prot_pkg::rsp_s rsp,
    input wire logic array_grant,
    input wire logic array_deny,
    input wire logic region23_write_ok,
    input wire logic region3_read_pw,
    input wire logic nv_config_lock,
    input wire logic [31:0] pointer_region_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_status_req;
        cmd.valid && (cmd.opcode == `CMD_READ_PROT_STATUS ||
            (cmd.opcode == `CMD_GENERIC_READ && cmd.addr == `ADDR_PROT_STATUS));
    endsequence
    sequence s_status_ans;
        rsp.valid && rsp.data[31:7] == 25'h0 && rsp.data[5:1] == 5'h00;
    endsequence
    chk_status_read: assert property (s_status_req |=> s_status_ans)
        else $error("status read answer wrong");
    chk_lock_read: assert property (cmd.valid && (cmd.opcode == `CMD_BLOCK_LOCK_READ ||
        cmd.opcode == `CMD_BLOCK_LOCK_READ4) |=> rsp.valid && rsp.data[31:8] == 24'h0)
        else $error("lock read answer wrong");
    chk_lock_cmd: assert property (cmd.valid && cmd.opcode == `CMD_LOCK_PROT |->
        ##[1:2] nv_config_lock) else $error("lock command not applied");
    chk_lock_sticky: assert property (nv_config_lock |=> nv_config_lock)
        else $error("lock bit dropped");
    chk_write_guard: assert property (region23_write_ok == nv_config_lock)
        else $error("region write guard wrong");
    chk_pw_guard: assert property (region3_read_pw |-> !nv_config_lock)
        else $error("read password while unlocked");
    chk_ptr_frozen: assert property (!nv_config_lock && cmd.valid &&
        (cmd.opcode == `CMD_SET_POINTER || cmd.opcode == `CMD_SET_POINTER4) &&
        !$past(cmd.valid && cmd.opcode == `CMD_LOCK_PROT) |=> $stable(pointer_region_reg)[*2])
        else $error("pointer changed while frozen");
    chk_array_once: assert property (array_req.valid |=> array_grant != array_deny)
        else $error("no single array answer");
    chk_array_idle: assert property (!array_req.valid |=> !(array_grant || array_deny))
        else $error("array answer without request");
    chk_protect_all: assert property (array_req.valid && !pointer_region_reg[`PTR_EN_BIT] &&
        pointer_region_reg[`PTR_ALL_BIT] |=> array_deny) else $error("protect all not denied");
endmodule // flash_prot_checker

// [tb/flash_region_block_protection_tb_top.sv]
`timescale 1ns/1ps
`include "flash_prot_map.svh"

module flash_region_block_protection_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] mode = 8'hff;
    flash_prot_pkg::cmd_s cmd;
    flash_prot_pkg::access_s array_req = '0;
    flash_prot_pkg::rsp_s rsp;
    logic array_grant, array_deny, region23_write_ok, region3_read_pw, nv_config_lock;
    logic [31:0] pointer_region_reg, ptr, a;
    logic [31:0] rsp_q[$];
    logic arr_q[$];
    logic exp_deny;
    int bad_count = 0;
    int comparisons = 0;
    logic [7:0] ops[6] = '{`CMD_BLOCK_UNLOCK, `CMD_BLOCK_LOCK4, `CMD_BLOCK_UNLOCK4,
        `CMD_GLOBAL_LOCK, `CMD_GLOBAL_UNLOCK, `CMD_BLOCK_LOCK};
    logic [7:0] vals[6] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};

    always #5 clk_sys = ~clk_sys;

    host_cmd_model host_cmd_model_i (.clk_sys(clk_sys), .cmd(cmd));
    flash_region_block_protection flash_region_block_protection_i (
        .clk_sys(clk_sys), .rst(rst), .protection_mode_bits(mode), .cmd(cmd),
        .array_req(array_req), .rsp(rsp), .array_grant(array_grant),
        .array_deny(array_deny), .region23_write_ok(region23_write_ok),
        .region3_read_pw(region3_read_pw), .nv_config_lock(nv_config_lock),
        .pointer_region_reg(pointer_region_reg));

    task automatic fail(input string msg);
        bad_count++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) fail("flag mismatch");
    endtask
    task automatic rd(input logic [7:0] op, input logic [31:0] ad, input logic [31:0] exp);
        rsp_q.push_back(exp);
        host_cmd_model_i.issue(op, ad, 32'h0);
    endtask
    task automatic arr(input logic [31:0] ad, input logic exp);
        host_cmd_model_i.idle();
        arr_q.push_back(exp);
        array_req = {1'b1, ad};
        @(negedge clk_sys);
        array_req = {1'b0, ~ad};
    endtask
    task automatic do_reset(input logic [7:0] m);
        host_cmd_model_i.idle();
        rst = 1'b1;
        mode = m;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    function automatic logic deny_of(input logic [31:0] p, input logic [31:0] ad);
        if (p[10]) return 1'b0;
        if (p[11]) return 1'b1;
        return p[9] ? (ad[22:12] <= p[22:12]) : (ad[22:12] >= p[22:12]);
    endfunction

    // ------------------------------------------------
    // answer monitor
    // ------------------------------------------------
    always @(negedge clk_sys) begin
        if (rsp.valid === 1'b1) begin
            if (rsp_q.size() == 0) fail("unexpected answer");
            else cmp_data(rsp.data, rsp_q.pop_front());
        end
        if ((array_grant | array_deny) === 1'b1) begin
            if (arr_q.size() == 0) fail("unexpected grant");
            else begin
                exp_deny = arr_q.pop_front();
                cmp_bit(array_deny, exp_deny);
                cmp_bit(array_grant, ~exp_deny);
            end
        end
    end

    initial begin
        void'($urandom(20));
        repeat (20) @(negedge clk_sys);
        cmp_data(pointer_region_reg, `PTR_RESET);
        do_reset(8'hff);
        cmp_bit(nv_config_lock, 1'b1);
        cmp_bit(region3_read_pw, 1'b0);
        rd(`CMD_READ_PROT_STATUS, 32'h0, 32'h41);
        rd(`CMD_GENERIC_READ, `ADDR_PROT_STATUS, 32'h41);
        host_cmd_model_i.issue(`CMD_GENERIC_READ, 32'h50, 32'h0);
        a = {9'h0, 7'($urandom()), 16'h0};
        rd(`CMD_BLOCK_LOCK_READ, a, 32'h0);
        arr(a, 1'b1);
        // write then read in the very next cycle
        for (int i = 0; i < 6; i++) begin
            host_cmd_model_i.issue(ops[i], a, 32'h0);
            rd(i[0] ? `CMD_BLOCK_LOCK_READ4 : `CMD_BLOCK_LOCK_READ, a, {24'h0, vals[i]});
            arr(a, vals[i] == 8'h00);
        end
        host_cmd_model_i.issue(`CMD_GLOBAL_UNLOCK, 32'h0, 32'h0);
        rd(`CMD_BLOCK_LOCK_READ, a ^ 32'h0001_0000, 32'hff);
        // fb gets the value in both fields; 71 and e3 carry it in the data field, with the pointer register address
        for (int i = 0; i < 4; i++) begin
            ptr = {9'h1ff, 11'($urandom()), i[1], i == 3, i[0], 9'h1ff};
            host_cmd_model_i.issue(i[0] ? `CMD_SET_POINTER :
                (i[1] ? `CMD_SET_POINTER4 : `CMD_GENERIC_WRITE),
                i[0] ? ptr : `ADDR_POINTER_REGION, ptr);
            rd(`CMD_GENERIC_READ, `ADDR_POINTER_REGION, ptr);
            repeat (2) begin
                a = {9'h0, 23'($urandom())};
                arr(a, deny_of(ptr, a));
            end
        end
        do_reset(8'hae);
        cmp_bit(nv_config_lock, 1'b0);
        cmp_bit(region23_write_ok, 1'b0);
        cmp_bit(region3_read_pw, 1'b1);
        rd(`CMD_READ_PROT_STATUS, 32'h0, 32'h0);
        rd(`CMD_BLOCK_LOCK_READ4, 32'h0, 32'hef);
        arr(32'h0, 1'b0);
        host_cmd_model_i.issue(`CMD_SET_POINTER, 32'h0, 32'h0);
        host_cmd_model_i.issue(`CMD_GENERIC_WRITE, `ADDR_POINTER_REGION, 32'h0);
        rd(`CMD_GENERIC_READ, `ADDR_POINTER_REGION, `PTR_RESET);
        host_cmd_model_i.issue(`CMD_LOCK_PROT, 32'h0, 32'h0);
        host_cmd_model_i.idle();
        rd(`CMD_READ_PROT_STATUS, 32'h0, 32'h01);
        host_cmd_model_i.issue(`CMD_GENERIC_WRITE, `ADDR_POINTER_REGION, 32'hff80_09ff);
        rd(`CMD_GENERIC_READ, `ADDR_POINTER_REGION, 32'hff80_09ff);
        do_reset(8'hfb);
        cmp_bit(nv_config_lock, 1'b0);
        for (int n = 0; n < 20 && rsp_q.size() + arr_q.size() > 0; n++) @(negedge clk_sys);
        if (rsp_q.size() + arr_q.size() > 0) fail("missing answer");
        tally_and_finish();
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
endmodule // flash_region_block_protection_tb_top

bind flash_region_block_protection flash_prot_checker flash_prot_checker_i (
    .clk_sys(clk_sys), .rst(rst), .protection_mode_bits(protection_mode_bits), .cmd(cmd),
    .array_req(array_req), .rsp(rsp), .array_grant(array_grant), .array_deny(array_deny),
    .region23_write_ok(region23_write_ok), .region3_read_pw(region3_read_pw),
    .nv_config_lock(nv_config_lock), .pointer_region_reg(pointer_region_reg));

// [tb/host_cmd_model.sv]
`timescale 1ns/1ps

module host_cmd_model (
    // clock
    input wire logic clk_sys,
    // decoded command toward the device
    output flash_prot_pkg::cmd_s cmd
);
    initial cmd = '0;
    task automatic issue(input logic [7:0] op, input logic [31:0] a, input logic [31:0] wd);
        @(negedge clk_sys);
        cmd = {1'b1, op, a, wd};
    endtask
    // released fields toggle so a stale value never looks valid
    task automatic idle();
        @(negedge clk_sys);
        cmd = {1'b0, ~cmd.opcode, ~cmd.addr, ~cmd.wdata};
    endtask
endmodule // host_cmd_model
